// ---- shared/irq_ctrl_defines.vh ----
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH

// Register offsets
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_PIN 4'h2
// Control register fields
`define CTRL_GLOBAL_BIT 0
`define CTRL_SERIAL_EN_BIT 1
`define CTRL_EXT_EN_BIT 2
// Status register fields
`define STAT_SERIAL_FLAG_BIT 0
`define STAT_EXT_FLAG_BIT 1
`define STAT_STACK_FULL_BIT 2
`define STAT_ASLEEP_BIT 3
// Pin register fields
`define PIN_DIR_BIT 0
`define PIN_PULL_BIT 1
`define PIN_LEVEL_BIT 2
// Vectors
`define VEC_SERIAL 13'h0010
`define VEC_EXT 13'h0014
// Reset values
`define CTRL_RESET 8'h00
`define PIN_RESET 8'h01
`endif

// ---- design/fall_edge_detect.v ----
`include "irq_ctrl_defines.vh"

module fall_edge_detect
(
    // Clock and reset
    input wire clk_sys,
    input wire resetn,
    // Raw pin and gate
    input wire pin_in,
    input wire gate,
    // Detected falling edge
    output reg fall_ff
);

reg sync1_ff;
reg sync2_ff;
reg last_ff;

// Two-stage synchroniser, then edge compare on the second stage only
always @(posedge clk_sys)
begin
    if (!resetn)
    begin
        sync1_ff <= 1'b1;
        sync2_ff <= 1'b1;
        last_ff <= 1'b1;
        fall_ff <= 1'b0;
    end
    else
    begin
        sync1_ff <= pin_in;
        sync2_ff <= sync1_ff;
        // Edge history held high while gated, so enabling on a low pin counts as an edge
        last_ff <= gate ? sync2_ff : 1'b1;
        fall_ff <= gate & last_ff & ~sync2_ff;
    end
end

endmodule

// ---- design/serial_and_pin_interrupt_ctrl.v ----
// The implementer's own choices: the strobed register port and the register offsets.
`include "irq_ctrl_defines.vh"

module serial_and_pin_interrupt_ctrl
#(
    parameter PC_W = 13
)
(
    // Clock and reset
    input wire clk_sys,
    input wire resetn,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_ff,
    // Serial module events
    input wire serial_byte_done,
    input wire serial_addr_match,
    // Shared port pin
    input wire shared_port_pin,
    output reg shared_pin_pull_en_ff,
    // Sequencer and stack
    input wire t2_rise,
    input wire stack_full,
    input wire [PC_W-1:0] pc_now,
    input wire power_down,
    output reg call_ff,
    output reg [PC_W-1:0] call_vector_ff,
    output reg push_ff,
    output reg [PC_W-1:0] push_data_ff,
    output reg wake_ff
);

// Control and pin configuration
reg global_irq_enable_ff;
reg serial_irq_enable_ff;
reg ext_irq_enable_ff;
reg serial_irq_flag_ff;
reg ext_irq_flag_ff;
reg shared_pin_direction_bit_ff;
reg asleep_ff;
wire ext_fall;
wire sel_serial;
wire sel_ext;
wire take;
wire wr_ctrl;
wire wr_stat;
wire wr_pin;
wire serial_set;
wire serial_go;
wire ext_go;
wire [7:0] ctrl_word;
wire [7:0] stat_word;
wire [7:0] pin_word;
// Second copy of the pin for readback; the raw pin is never read by logic
reg pin_sync1_ff;
reg pin_sync2_ff;

// Reset images as vectors so single bits are picked by position, not by shifting
localparam [7:0] CTRL_RST = `CTRL_RESET;
localparam [7:0] PIN_RST = `PIN_RESET;
// Vectors sized to the program counter so a narrower core truncates on purpose
localparam [PC_W-1:0] VEC_SER_W = `VEC_SERIAL;
localparam [PC_W-1:0] VEC_EXT_W = `VEC_EXT;

// Pin edge detection, live only while the external enable is set
fall_edge_detect u_edge
(
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pin_in(shared_port_pin),
    .gate(ext_irq_enable_ff),
    .fall_ff(ext_fall)
);

assign wr_ctrl = reg_wr & (reg_addr == `REG_CTRL);
assign wr_stat = reg_wr & (reg_addr == `REG_STATUS);
assign wr_pin = reg_wr & (reg_addr == `REG_PIN);
assign serial_set = serial_byte_done | serial_addr_match;

// Per-source eligibility; flags alone are not enough
assign serial_go = global_irq_enable_ff & serial_irq_enable_ff & serial_irq_flag_ff;
assign ext_go = global_irq_enable_ff & ext_irq_enable_ff & ext_irq_flag_ff;

// Serial outranks external when both are ready
assign sel_serial = serial_go;
assign sel_ext = ext_go & ~serial_go;

// Acknowledge only at a T2 edge with stack room and no call in flight
assign take = t2_rise & ~stack_full & ~call_ff & (serial_go | ext_go);

// Control register: global enable self-clears on service
always @(posedge clk_sys)
begin
    if (!resetn)
    begin
        global_irq_enable_ff <= CTRL_RST[`CTRL_GLOBAL_BIT];
        serial_irq_enable_ff <= 1'b0;
        ext_irq_enable_ff <= 1'b0;
    end
    else
    begin
        if (take)
            global_irq_enable_ff <= 1'b0;
        else if (wr_ctrl)
            global_irq_enable_ff <= reg_wdata[`CTRL_GLOBAL_BIT];
        if (wr_ctrl)
        begin
            serial_irq_enable_ff <= reg_wdata[`CTRL_SERIAL_EN_BIT];
            ext_irq_enable_ff <= reg_wdata[`CTRL_EXT_EN_BIT];
        end
    end
end

// Request flags: hold regardless of enable, set beats every clear
always @(posedge clk_sys)
begin
    if (!resetn)
    begin
        serial_irq_flag_ff <= 1'b0;
        ext_irq_flag_ff <= 1'b0;
    end
    else
    begin
        if (serial_set)
            serial_irq_flag_ff <= 1'b1;
        else if (take & sel_serial)
            serial_irq_flag_ff <= 1'b0;
        else if (wr_stat & ~reg_wdata[`STAT_SERIAL_FLAG_BIT])
            serial_irq_flag_ff <= 1'b0;
        if (ext_fall)
            ext_irq_flag_ff <= 1'b1;
        else if (take & sel_ext)
            ext_irq_flag_ff <= 1'b0;
        else if (wr_stat & ~reg_wdata[`STAT_EXT_FLAG_BIT])
            ext_irq_flag_ff <= 1'b0;
    end
end

// Pin configuration: direction is software's to set, pull-up is kept as chosen
always @(posedge clk_sys)
begin
    if (!resetn)
    begin
        shared_pin_direction_bit_ff <= PIN_RST[`PIN_DIR_BIT];
        shared_pin_pull_en_ff <= PIN_RST[`PIN_PULL_BIT];
    end
    else if (wr_pin)
    begin
        shared_pin_direction_bit_ff <= reg_wdata[`PIN_DIR_BIT];
        // Pull choice is not overridden by interrupt use
        shared_pin_pull_en_ff <= reg_wdata[`PIN_PULL_BIT];
    end
end

// Vectored call: only the program counter is pushed
always @(posedge clk_sys)
begin
    if (!resetn)
    begin
        call_ff <= 1'b0;
        push_ff <= 1'b0;
        call_vector_ff <= {PC_W{1'b0}};
        push_data_ff <= {PC_W{1'b0}};
    end
    else
    begin
        call_ff <= take;
        push_ff <= take;
        if (take)
        begin
            call_vector_ff <= sel_serial ? VEC_SER_W : VEC_EXT_W;
            push_data_ff <= pc_now;
        end
    end
end

// Wake from power-down on any pending flag, whatever the enables
always @(posedge clk_sys)
begin
    if (!resetn)
    begin
        wake_ff <= 1'b0;
        asleep_ff <= 1'b0;
    end
    else
    begin
        asleep_ff <= power_down;
        wake_ff <= power_down & (serial_irq_flag_ff | ext_irq_flag_ff);
    end
end

// Pin level for readback passes two flops; it arrives from outside the clock domain
always @(posedge clk_sys)
begin
    if (!resetn)
    begin
        pin_sync1_ff <= 1'b1;
        pin_sync2_ff <= 1'b1;
    end
    else
    begin
        pin_sync1_ff <= shared_port_pin;
        pin_sync2_ff <= pin_sync1_ff;
    end
end

// Register images assembled once so the read mux stays a plain select
assign ctrl_word = {5'h00, ext_irq_enable_ff, serial_irq_enable_ff, global_irq_enable_ff};
assign stat_word = {4'h0, asleep_ff, stack_full, ext_irq_flag_ff, serial_irq_flag_ff};
assign pin_word = {5'h00, pin_sync2_ff, shared_pin_pull_en_ff, shared_pin_direction_bit_ff};

// Read data valid the cycle after the strobe; unmapped reads zero
always @(posedge clk_sys)
begin
    if (!resetn)
        reg_rdata_ff <= 8'h00;
    else if (reg_rd)
    begin
        case (reg_addr)
            `REG_CTRL:
                reg_rdata_ff <= ctrl_word;
            `REG_STATUS:
                reg_rdata_ff <= stat_word;
            `REG_PIN:
                reg_rdata_ff <= pin_word;
            default:
                reg_rdata_ff <= 8'h00;
        endcase
    end
    else
        reg_rdata_ff <= 8'h00;
end

endmodule

// ---- bench/irq_ctrl_asserts.sv ----
`include "irq_ctrl_defines.vh"
module irq_ctrl_asserts #(parameter PC_W = 13)
(
    // Clock, reset and register port
    input wire clk_sys, input wire resetn, input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata, input wire reg_wr, input wire shared_pin_pull_en_ff,
    // Sequencer and stack
    input wire t2_rise, input wire stack_full, input wire [PC_W-1:0] pc_now,
    input wire power_down, input wire call_ff, input wire [PC_W-1:0] call_vector_ff,
    input wire push_ff, input wire [PC_W-1:0] push_data_ff, input wire wake_ff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Every call pushes the PC seen at the take edge, and nothing else
    call_push_a: assert property (call_ff == push_ff) else $error("call without push");
    push_pc_a: assert property (call_ff |-> push_data_ff == $past(pc_now))
        else $error("pushed value is not the PC");
    // Global enable drops at service, so a second call cannot follow at once
    one_call_a: assert property (call_ff |=> !call_ff) else $error("back to back calls");
    vector_a: assert property (call_ff |-> call_vector_ff == `VEC_SERIAL
        || call_vector_ff == `VEC_EXT) else $error("bad vector");
    full_hold_a: assert property ($past(stack_full) |-> !call_ff) else $error("call on full");
    t2_only_a: assert property (!$past(t2_rise) |-> !call_ff) else $error("call off T2");
    pull_a: assert property ($past(reg_wr && reg_addr == `REG_PIN) |->
        shared_pin_pull_en_ff == $past(reg_wdata[`PIN_PULL_BIT])) else $error("pull lost");
    wake_a: assert property (!$past(power_down) |-> !wake_ff) else $error("wake while awake");
endmodule
bind serial_and_pin_interrupt_ctrl irq_ctrl_asserts #(.PC_W(PC_W)) chk (.clk_sys, .resetn,
    .reg_addr, .reg_wdata, .reg_wr, .shared_pin_pull_en_ff, .t2_rise, .stack_full, .pc_now,
    .power_down, .call_ff, .call_vector_ff, .push_ff, .push_data_ff, .wake_ff);

// ---- bench/seq_stack_model.sv ----
module seq_stack_model #(parameter DEPTH = 8)
(
    // Clock and reset
    input wire clk_sys, input wire resetn,
    // Design side and bench pop request
    input wire push_ff, input wire pop,
    output logic t2_rise, output logic stack_full, output logic [12:0] pc_now
);
    timeunit 1ns;
    timeprecision 1ns;
    int depth;
    logic [1:0] phase;
    // T2 every fourth cycle; PC steps each cycle so a stale push shows
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            depth <= 0;
            phase <= 2'h0;
            pc_now <= 13'h0100;
        end
        else
        begin
            phase <= phase + 2'h1;
            pc_now <= pc_now + 13'h0001;
            depth <= depth + (push_ff ? 1 : 0) - (pop ? 1 : 0);
        end
    end
    assign t2_rise = resetn && phase == 2'h3;
    assign stack_full = depth >= DEPTH;
endmodule

// ---- bench/test_serial_and_pin_interrupt_ctrl.sv ----
`include "irq_ctrl_defines.vh"
module test_serial_and_pin_interrupt_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0, power_down = 0, pop = 0;
    logic serial_byte_done = 0, serial_addr_match = 0, shared_port_pin = 1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata_ff;
    logic t2_rise, stack_full, call_ff, push_ff, wake_ff, shared_pin_pull_en_ff;
    logic [12:0] pc_now, call_vector_ff, push_data_ff, v;
    int n_mismatch = 0, total_checks = 0, cyc = 0, seed = 32'h8a15, m_depth = 0, i, k;
    initial forever #20 clk_sys = ~clk_sys;
    // Small stack so the full case is reached after three takes
    seq_stack_model #(.DEPTH(3)) far (.clk_sys, .resetn, .push_ff, .pop, .t2_rise,
        .stack_full, .pc_now);
    serial_and_pin_interrupt_ctrl dut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata_ff, .serial_byte_done, .serial_addr_match, .shared_port_pin,
        .shared_pin_pull_en_ff, .t2_rise, .stack_full, .pc_now, .power_down, .call_ff,
        .call_vector_ff, .push_ff, .push_data_ff, .wake_ff);
    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [12:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1 chk({5'h0, reg_rdata_ff}, exp);
    endtask
    task automatic ser(input int w);
        @(posedge clk_sys);
        if (w) serial_addr_match <= 1;
        else serial_byte_done <= 1;
        @(posedge clk_sys);
        serial_byte_done <= 0;
        serial_addr_match <= 0;
        repeat (3) @(posedge clk_sys);
    endtask
    // Bounded wait for the call; the stack model grows by one
    task automatic take(input logic [12:0] vec);
        for (i = 0; i < 30 && call_ff !== 1'b1; i++) @(posedge clk_sys) #1;
        chk({12'h0, call_ff}, 13'h1);
        chk(call_vector_ff, vec);
        m_depth++;
    endtask
    initial
    begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1;
        rd(`REG_CTRL, `CTRL_RESET);
        rd(`REG_PIN, 13'h05);
        rd(4'hf, 13'h00);
        // Both serial events set the flag with every enable clear
        for (k = 0; k < 2; k++)
        begin
            ser(k);
            rd(`REG_STATUS, 13'h01);
            wr(`REG_STATUS, 8'h00);
            rd(`REG_STATUS, 13'h00);
        end
        // A pin fall with its enable clear is not an interrupt input
        shared_port_pin <= 0;
        repeat (8) @(posedge clk_sys);
        rd(`REG_STATUS, 13'h00);
        shared_port_pin <= 1;
        ser(0);
        wr(`REG_CTRL, 8'h03);
        take(`VEC_SERIAL);
        rd(`REG_CTRL, 13'h02);
        rd(`REG_STATUS, 13'h00);
        // Both pending: serial goes first, external flag waits
        wr(`REG_CTRL, 8'h06);
        ser(1);
        shared_port_pin <= 0;
        repeat (8) @(posedge clk_sys);
        wr(`REG_CTRL, 8'h07);
        take(`VEC_SERIAL);
        rd(`REG_STATUS, 13'h02);
        wr(`REG_CTRL, 8'h05);
        take(`VEC_EXT);
        rd(`REG_STATUS, m_depth >= 3 ? 13'h04 : 13'h00);
        // Full stack holds the request until one entry pops
        ser(0);
        wr(`REG_CTRL, 8'h03);
        repeat (12) @(posedge clk_sys);
        rd(`REG_STATUS, m_depth >= 3 ? 13'h05 : 13'h01);
        pop <= 1;
        @(posedge clk_sys);
        pop <= 0;
        m_depth--;
        take(`VEC_SERIAL);
        power_down <= 1;
        ser(1);
        #1 chk({12'h0, wake_ff}, 13'h1);
        // Random pull choices with the pin set as input and the external enable clear
        for (k = 0; k < 4; k++)
        begin
            v = 13'($random(seed));
            wr(`REG_PIN, {6'h0, v[1], 1'b1});
            #1 chk({12'h0, shared_pin_pull_en_ff}, {12'h0, v[1]});
        end
        report_and_stop;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            report_and_stop;
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
endmodule
